// ==== adcctl_cfg.svh ====
`ifndef ADCCTL_CFG_SVH
`define ADCCTL_CFG_SVH
`define ADCCTL_OFS_CTRL      12'h000
`define ADCCTL_OFS_CLKPWR    12'h004
`define ADCCTL_OFS_RESULT_HI 12'h008
`define ADCCTL_OFS_RESULT_LO 12'h00c
`define ADCCTL_OFS_IRQ       12'h010
`define ADCCTL_BIT_START     7
`define ADCCTL_BIT_BUSY      6
`define ADCCTL_BIT_TEST      7
`define ADCCTL_BIT_PWROFF    6
`define ADCCTL_RST_CTRL      8'h40
`define ADCCTL_RST_CLKPWR    8'h80
`define ADCCTL_CONV_CLKS     5'h10
`endif

// ==== adcctl_pkg.sv ====
package adcctl_pkg;
  typedef enum logic [1:0] {
    ADCCTL_IDLE  = 2'b00,
    ADCCTL_RESET = 2'b01,
    ADCCTL_CONV  = 2'b11
  } adcctl_state_e;
  typedef logic [2:0] adcctl_code_t;
endpackage

// ==== adcctl_top.sv ====
`timescale 1ns/100ps
`include "adcctl_cfg.svh"
module adcctl_top #(
  parameter bit EIGHT_INPUTS = 1'b1
) (
  // Clock and reset
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  // AXI4-Lite slave
  input  wire logic [11:0]  S_AXI_AWADDR,
  input  wire logic         S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  input  wire logic [31:0]  S_AXI_WDATA,
  input  wire logic [3:0]   S_AXI_WSTRB,
  input  wire logic         S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  wire logic         S_AXI_BREADY,
  input  wire logic [11:0]  S_AXI_ARADDR,
  input  wire logic         S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  wire logic         S_AXI_RREADY,
  // Converter core
  output logic              CONV_CLK,
  output logic              CONV_RESET,
  output logic              CONV_POWER_DOWN,
  output logic [2:0]        CONV_CHANNEL,
  input  wire logic [11:0]  CONV_RESULT,
  // Pins and interrupt
  output logic [7:0]        ANALOG_INPUTS_EN,
  output logic              IRQ
);
  import adcctl_pkg::*;

  logic [7:0]    start_sh;
  logic          start_bit;
  logic [5:0]    analog_input_config_channel;
  logic          test_bit;
  logic          converter_power_off;
  adcctl_code_t  converter_clock_select;
  logic          conversion_busy_flag;
  logic          irq_flag;
  logic          irq_enable;
  logic [11:0]   result;
  adcctl_state_e state;
  logic [4:0]    div_cnt;
  logic          conv_clk_q;
  logic [4:0]    period_cnt;
  logic [11:0]   aw_addr;
  logic          aw_held;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          w_held;
  logic [31:0]   rdata;

  // Control fields.
  wire adcctl_code_t analog_input_config = analog_input_config_channel[5:3];
  wire adcctl_code_t channel_select      = analog_input_config_channel[2:0];
  wire powered_down = converter_power_off || (analog_input_config == 3'h0);

  // Clock divider; half period in system clocks, 0 means undivided.
  logic [4:0] half_div;
  always_comb begin
    unique case (converter_clock_select)
      3'h0:    half_div = 5'h01;
      3'h1:    half_div = 5'h04;
      3'h2:    half_div = 5'h10;
      3'h4:    half_div = 5'h00;
      3'h5:    half_div = 5'h02;
      3'h6:    half_div = 5'h08;
      default: half_div = 5'h01; // Undefined codes fall back to divide-by-two.
    endcase
  end
  wire div_wrap  = (div_cnt + 5'h01 >= half_div);
  wire conv_tick = (half_div == 5'h00) ? 1'b1 : (div_wrap && conv_clk_q);

  // Bus decode.
  wire do_write  = aw_held && w_held && !S_AXI_BVALID;
  wire wr_ctrl   = do_write && (aw_addr == `ADCCTL_OFS_CTRL) && w_strb[0];
  wire wr_clkpwr = do_write && (aw_addr == `ADCCTL_OFS_CLKPWR) && w_strb[0];
  wire wr_irq    = do_write && (aw_addr == `ADCCTL_OFS_IRQ) && w_strb[0];
  wire wr_known  = (aw_addr == `ADCCTL_OFS_CTRL) || (aw_addr == `ADCCTL_OFS_CLKPWR) ||
                   (aw_addr == `ADCCTL_OFS_IRQ);
  wire rd_known  = (S_AXI_ARADDR <= `ADCCTL_OFS_IRQ) && (S_AXI_ARADDR[1:0] == 2'h0);
  wire rd_take   = S_AXI_ARVALID && !S_AXI_RVALID;
  wire new_start = wr_ctrl ? w_data[`ADCCTL_BIT_START] : start_bit;

  // Start pulse: rise holds reset, the following fall begins the conversion.
  wire start_rise = !start_bit && new_start;
  wire start_fall = start_bit && !new_start;
  wire conv_done  = (state == ADCCTL_CONV) && conv_tick && (period_cnt == `ADCCTL_CONV_CLKS - 5'h01);

  adcctl_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ADCCTL_IDLE:  if (start_rise) next_state = ADCCTL_RESET;
      ADCCTL_RESET: if (start_fall) next_state = powered_down ? ADCCTL_IDLE : ADCCTL_CONV;
      ADCCTL_CONV: begin
        if (start_rise)        next_state = ADCCTL_RESET;
        else if (powered_down) next_state = ADCCTL_IDLE;
        else if (conv_done)    next_state = ADCCTL_IDLE;
      end
      default: next_state = ADCCTL_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state      <= ADCCTL_IDLE;
      period_cnt <= 5'h00;
    end else begin
      state      <= next_state;
      period_cnt <= (state != ADCCTL_CONV) ? 5'h00 : period_cnt + (conv_tick ? 5'h01 : 5'h00);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      div_cnt    <= 5'h00;
      conv_clk_q <= 1'b0;
    end else if (half_div != 5'h00 && div_wrap) begin
      div_cnt    <= 5'h00;
      conv_clk_q <= !conv_clk_q;
    end else begin
      div_cnt    <= div_cnt + 5'h01;
    end
  end

  // Registers written by software.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      start_bit                   <= 1'b0;
      analog_input_config_channel <= 6'h00;
      test_bit                    <= 1'b1;
      converter_power_off         <= 1'b0;
      converter_clock_select      <= 3'h0;
      irq_enable                  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        start_bit                   <= w_data[`ADCCTL_BIT_START];
        analog_input_config_channel <= w_data[5:0];
      end
      if (wr_clkpwr) begin
        test_bit               <= w_data[`ADCCTL_BIT_TEST]; // Test-only bit, no effect here.
        converter_power_off    <= w_data[`ADCCTL_BIT_PWROFF];
        converter_clock_select <= w_data[2:0];
      end
      if (wr_irq) irq_enable <= w_data[1];
    end
  end

  // Busy flag, request flag and result capture; the set beats a software clear.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      conversion_busy_flag <= 1'b1;
      irq_flag             <= 1'b0;
      result               <= 12'h000;
    end else begin
      if (next_state == ADCCTL_RESET || next_state == ADCCTL_CONV) conversion_busy_flag <= 1'b1;
      else if (conv_done) conversion_busy_flag <= 1'b0;
      if (conv_done) begin
        irq_flag <= 1'b1;
        result   <= CONV_RESULT;
      end else if (wr_irq && w_data[0]) begin
        irq_flag <= 1'b0;
      end
    end
  end

  // Analog enables per configuration code.
  logic [7:0] next_analog_en;
  always_comb begin
    unique case (analog_input_config)
      3'h0:    next_analog_en = 8'h00;
      3'h1:    next_analog_en = 8'h01;
      3'h2:    next_analog_en = 8'h03;
      3'h3:    next_analog_en = 8'h07;
      3'h4:    next_analog_en = 8'h0f;
      3'h5:    next_analog_en = EIGHT_INPUTS ? 8'h1f : 8'h0f;
      3'h6:    next_analog_en = EIGHT_INPUTS ? 8'h3f : 8'h0f;
      default: next_analog_en = EIGHT_INPUTS ? 8'hff : 8'h0f;
    endcase
  end

  // An enable high overrides the port direction and drops the pull-high.
  assign ANALOG_INPUTS_EN = next_analog_en;
  assign CONV_CLK         = (half_div == 5'h00) ? REF_CLK : conv_clk_q;
  assign CONV_RESET       = (state != ADCCTL_CONV);
  assign CONV_POWER_DOWN  = powered_down;
  // The four-input variant ignores the top select bit, so codes 1xx select channels 0 to 3.
  assign CONV_CHANNEL     = EIGHT_INPUTS ? channel_select : {1'b0, channel_select[1:0]};
  assign IRQ              = irq_flag && irq_enable;

  // Read mux.
  wire [7:0] ctrl_rd   = {start_bit, conversion_busy_flag, analog_input_config_channel};
  wire [7:0] clkpwr_rd = {test_bit, converter_power_off, 3'h0, converter_clock_select};
  always_comb begin
    unique case (S_AXI_ARADDR)
      `ADCCTL_OFS_CTRL:      rdata = {24'h0, ctrl_rd};
      `ADCCTL_OFS_CLKPWR:    rdata = {24'h0, clkpwr_rd};
      `ADCCTL_OFS_RESULT_HI: rdata = {24'h0, result[11:4]};
      `ADCCTL_OFS_RESULT_LO: rdata = {24'h0, result[3:0], 4'h0};
      `ADCCTL_OFS_IRQ:       rdata = {30'h0, irq_enable, irq_flag};
      default:               rdata = 32'h0;
    endcase
  end

  // AXI4-Lite handshakes.
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_known ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (rd_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rdata;
        S_AXI_RRESP  <= rd_known ? 2'h0 : 2'h2;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// ==== adcctl_sva.sv ====
`timescale 1ns/100ps
module adcctl_sva (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // Bus answers
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Converter side
  input wire logic        CONV_RESET,
  input wire logic        CONV_POWER_DOWN,
  input wire logic [7:0]  ANALOG_INPUTS_EN,
  input wire logic        IRQ
);
  logic [9:0] conv_cyc;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || CONV_RESET) conv_cyc <= 10'h000;
    else conv_cyc <= conv_cyc + 10'h001;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_reset_state: assert property (disable iff (1'b0) !RST_N |=>
    CONV_RESET && CONV_POWER_DOWN && !IRQ && ANALOG_INPUTS_EN == 8'h00) else $error("bad reset state");
  a_no_inputs_pd: assert property (ANALOG_INPUTS_EN == 8'h00 |-> CONV_POWER_DOWN)
    else $error("inputs off but powered");
  a_inputs_prefix: assert property ((ANALOG_INPUTS_EN & (ANALOG_INPUTS_EN + 8'h01)) == 8'h00)
    else $error("input mask not contiguous");
  a_start_powered: assert property ($fell(CONV_RESET) |-> !CONV_POWER_DOWN)
    else $error("conversion began powered down");
  a_conv_length: assert property ($rose(CONV_RESET) |-> conv_cyc >= 10'h00f)
    else $error("conversion too short");
  a_irq_after_end: assert property ($rose(IRQ) |-> CONV_RESET)
    else $error("interrupt during conversion");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  c_conv: cover property ($fell(CONV_RESET));
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule
bind adcctl_top adcctl_sva u_adcctl_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .CONV_RESET(CONV_RESET),
  .CONV_POWER_DOWN(CONV_POWER_DOWN), .ANALOG_INPUTS_EN(ANALOG_INPUTS_EN), .IRQ(IRQ));

// ==== adcctl_core_model.sv ====
`timescale 1ns/100ps
module adcctl_core_model (
  // Converter control
  input wire logic        CONV_CLK,
  input wire logic        CONV_RESET,
  input wire logic        CONV_POWER_DOWN,
  input wire logic [2:0]  CONV_CHANNEL,
  // Result
  output logic [11:0]     CONV_RESULT
);
  // Outside a conversion the result keeps flipping, so a stale sample never looks valid.
  initial CONV_RESULT = 12'h000;
  always @(posedge CONV_CLK) begin
    if (CONV_RESET || CONV_POWER_DOWN) CONV_RESULT <= ~CONV_RESULT;
    else CONV_RESULT <= {CONV_CHANNEL, 9'h15a};
  end
endmodule

// ==== adcctl_top_tb.sv ====
`timescale 1ns/100ps
`include "adcctl_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module adcctl_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, cclk, crst, cpd, irq;
  logic [1:0]  bresp, rresp, eb;
  logic [2:0]  cch;
  logic [11:0] cres;
  logic [7:0]  ain, ch, n;
  logic [33:0] er;
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  int          mismatches = 0, tests_run = 0, cyc = 0, edges = 0;
  always #12.5 clk = ~clk;
  adcctl_top u_adcctl_top (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CONV_CLK(cclk), .CONV_RESET(crst),
    .CONV_POWER_DOWN(cpd), .CONV_CHANNEL(cch), .CONV_RESULT(cres), .ANALOG_INPUTS_EN(ain), .IRQ(irq));
  adcctl_core_model u_adcctl_core_model (.CONV_CLK(cclk), .CONV_RESET(crst), .CONV_POWER_DOWN(cpd),
    .CONV_CHANNEL(cch), .CONV_RESULT(cres));
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom % 2);
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= !(bvalid && bready);
    end while (!(bvalid && bready));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom % 2);
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      rready <= !(rvalid && rready);
    end while (!(rvalid && rready));
  endtask
  task wrap_up;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge cclk) if (!crst) edges++;
  // Answers are matched in order, so a lost or extra response shows up as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (bvalid && bready) begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
    if (rvalid && rready) begin
      er = exp_r.pop_front();
      `CHK({rresp, rdata}, er)
    end
    if (cyc > 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h734e));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADCCTL_OFS_CTRL, 32'h40, 2'h0);
    rd(`ADCCTL_OFS_CLKPWR, 32'h80, 2'h0);
    rd(12'h020, 32'h0, 2'h2);
    wr(12'h020, 8'h55, 2'h2);
    wr(`ADCCTL_OFS_CLKPWR, 8'hbd, 2'h0);
    rd(`ADCCTL_OFS_CLKPWR, 32'h85, 2'h0);
    for (int c = 0; c < 8; c++) begin
      ch = 8'($urandom % 8);
      n = (c == 7) ? 8'h08 : 8'(c);
      wr(`ADCCTL_OFS_CTRL, 8'(c * 8) | ch, 2'h0);
      `CHK(ain, 8'((9'h001 << n) - 9'h001))
      `CHK(cch, ch[2:0])
      `CHK(cpd, 1'(c == 0))
      rd(`ADCCTL_OFS_CTRL, 32'h40 | (c * 8) | ch, 2'h0);
    end
    wr(`ADCCTL_OFS_IRQ, 8'h02, 2'h0);
    wr(`ADCCTL_OFS_CLKPWR, 8'hc0, 2'h0);
    `CHK(cpd, 1'b1)
    wr(`ADCCTL_OFS_CTRL, 8'hbb, 2'h0);
    wr(`ADCCTL_OFS_CTRL, 8'h3b, 2'h0);
    repeat (100) @(posedge clk);
    `CHK({crst, irq}, 2'h2)
    for (int i = 0; i < 6; i++) begin
      ch = 8'($urandom % 8);
      wr(`ADCCTL_OFS_CLKPWR, 8'h80 | 8'(i < 3 ? i : i + 1), 2'h0);
      `CHK(cpd, 1'b0)
      wr(`ADCCTL_OFS_CTRL, 8'hb8 | ch, 2'h0);
      `CHK(crst, 1'b1)
      rd(`ADCCTL_OFS_CTRL, 32'hf8 | ch, 2'h0);
      edges = 0;
      wr(`ADCCTL_OFS_CTRL, 8'h38 | ch, 2'h0);
      rd(`ADCCTL_OFS_CTRL, 32'h78 | ch, 2'h0);
      for (int t = 0; t < 2000 && !irq; t++) @(posedge clk);
      `CHK(1'(edges >= 15 && edges <= 17), 1'b1)
      rd(`ADCCTL_OFS_CTRL, 32'h38 | ch, 2'h0);
      rd(`ADCCTL_OFS_RESULT_HI, 32'(ch * 32 + 32'h15), 2'h0);
      rd(`ADCCTL_OFS_RESULT_LO, 32'ha0, 2'h0);
      rd(`ADCCTL_OFS_IRQ, 32'h3, 2'h0);
      wr(`ADCCTL_OFS_IRQ, 8'h03, 2'h0);
      `CHK(irq, 1'b0)
    end
    wr(`ADCCTL_OFS_IRQ, 8'h00, 2'h0);
    wr(`ADCCTL_OFS_CTRL, 8'hb8, 2'h0);
    wr(`ADCCTL_OFS_CTRL, 8'h38, 2'h0);
    repeat (600) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`ADCCTL_OFS_IRQ, 32'h1, 2'h0);
    wrap_up();
  end
endmodule
